// ### src/gnio_pkg.sv
// constants shared by the grouped nibble i/o ports
// assumes a 4-bit register bus with bank zero data memory and a separate register file space
package gnio_pkg;
    localparam int unsigned NIB_W = 4;
    localparam int unsigned PORT_N = 3;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned BANK_W = 2;
    // register file address of the shared direction register
    localparam logic [7:0] ADDR_DIR_GROUPS = 8'h37;
    // bank zero data memory addresses of the port latches
    localparam logic [7:0] ADDR_PORT_A = 8'h70;
    localparam logic [7:0] ADDR_PORT_B = 8'h71;
    localparam logic [7:0] ADDR_PORT_C = 8'h72;
    localparam logic [1:0] DATA_BANK_ZERO = 2'h0;
    // direction field positions, 1 = output, 0 = input
    localparam int unsigned FIRST_PORT_DIR_SELECT = 0;
    localparam int unsigned SECOND_PORT_DIR_SELECT = 1;
    localparam int unsigned THIRD_PORT_DIR_SELECT = 2;
    localparam logic [2:0] DIR_RESET = 3'h0;
    localparam logic [3:0] LATCH_RESET = 4'hF;
    localparam logic [3:0] RDATA_IDLE = 4'h0;
    localparam logic [3:0] NIB_ALL_OFF = 4'hF;
    localparam logic [3:0] NIB_ALL_ON = 4'h0;
    localparam logic [1:0] SYNC_RESET = 2'h0;
    localparam logic [1:0] SYNC_SHIFT_IN = 2'h1;
endpackage

// ### src/gnio_rst_sync.sv
// reset release synchroniser
// assumes an asynchronous active-low reset and one clock
`timescale 1ns/1ps
module gnio_rst_sync (
    input wire logic i_clk,
    input wire logic i_rst_b,
    output logic o_rst_b
);
    logic [1:0] sync_ff;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sync_ff <= gnio_pkg::SYNC_RESET;
        end else begin
            sync_ff <= {sync_ff[0], gnio_pkg::SYNC_SHIFT_IN[0]};
        end
    end

    assign o_rst_b = sync_ff[1];
endmodule

// ### src/gnio_nibble_port.sv
// one 4-bit port: output latch and registered pin drive
// assumes direction and write strobe come from the top register decode
`timescale 1ns/1ps
module gnio_nibble_port #(
    parameter bit OPEN_DRAIN = 1'b0
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_wr,
    input wire logic [3:0] i_wdata,
    input wire logic i_dir_out,
    output logic [3:0] o_latch,
    output logic [3:0] o_pin_out,
    output logic [3:0] o_pin_oe_b,
    output logic o_pull_up_en
);
    logic [3:0] latch_ff;
    logic [3:0] pin_out_ff;
    logic [3:0] pin_oe_b_ff;
    logic pull_up_ff;

    // latch keeps writes in either direction
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            latch_ff <= gnio_pkg::LATCH_RESET;
        end else if (i_wr) begin
            latch_ff <= i_wdata;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < gnio_pkg::NIB_W; gi++) begin : g_bit
            always_ff @(posedge i_clk or negedge i_rst_b) begin
                if (!i_rst_b) begin
                    pin_out_ff[gi] <= 1'b0;
                    pin_oe_b_ff[gi] <= 1'b1;
                end else if (OPEN_DRAIN) begin
                    pin_out_ff[gi] <= 1'b0;
                    pin_oe_b_ff[gi] <= ~(i_dir_out & ~latch_ff[gi]);
                end else begin
                    pin_out_ff[gi] <= latch_ff[gi];
                    pin_oe_b_ff[gi] <= ~i_dir_out;
                end
            end
        end
    endgenerate

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pull_up_ff <= ~OPEN_DRAIN;
        end else begin
            pull_up_ff <= ~OPEN_DRAIN & ~i_dir_out;
        end
    end

    assign o_latch = latch_ff;
    assign o_pin_out = pin_out_ff;
    assign o_pin_oe_b = pin_oe_b_ff;
    assign o_pull_up_en = pull_up_ff;
endmodule

// ### src/gnio_top.sv
// three grouped-direction 4-bit general purpose ports with register access
// assumes one 25 MHz clock, pins synchronous to it, a watchdog reset pulse from the cpu
`timescale 1ns/1ps
module gnio_top (
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic i_wdt_rst,
    input wire logic [7:0] i_bus_addr,
    input wire logic i_bus_rf_sel,
    input wire logic [1:0] i_bus_bank,
    input wire logic [3:0] i_bus_wdata,
    input wire logic i_bus_wr,
    input wire logic i_bus_rd,
    output logic [3:0] o_bus_rdata,
    input wire logic [3:0] i_pa_in,
    output logic [3:0] o_pa_out,
    output logic [3:0] o_pa_oe_b,
    output logic o_pa_pull_up_en,
    input wire logic [3:0] i_pb_in,
    output logic [3:0] o_pb_out,
    output logic [3:0] o_pb_oe_b,
    input wire logic [3:0] i_pc_in,
    output logic [3:0] o_pc_out,
    output logic [3:0] o_pc_oe_b
);
    logic rst_b;
    logic [2:0] dir_ff;
    logic [2:0] nxt_dir;
    logic [3:0] rdata_ff;
    logic [3:0] nxt_rdata;
    logic [3:0] latch_a;
    logic [3:0] latch_b;
    logic [3:0] latch_c;
    logic hit_dir;
    logic hit_a;
    logic hit_b;
    logic hit_c;
    logic dm_bank0;

    gnio_rst_sync u_rst_sync (
        .i_clk(i_sys_clk),
        .i_rst_b(i_rst_b),
        .o_rst_b(rst_b)
    );

    // address decode
    assign dm_bank0 = !i_bus_rf_sel && (i_bus_bank == gnio_pkg::DATA_BANK_ZERO);
    assign hit_dir = i_bus_rf_sel && (i_bus_addr == gnio_pkg::ADDR_DIR_GROUPS);
    assign hit_a = dm_bank0 && (i_bus_addr == gnio_pkg::ADDR_PORT_A);
    assign hit_b = dm_bank0 && (i_bus_addr == gnio_pkg::ADDR_PORT_B);
    assign hit_c = dm_bank0 && (i_bus_addr == gnio_pkg::ADDR_PORT_C);

    // direction register, watchdog reset wins over a write
    always_comb begin
        nxt_dir = dir_ff;
        if (i_wdt_rst) begin
            nxt_dir = gnio_pkg::DIR_RESET;
        end else if (i_bus_wr && hit_dir) begin
            nxt_dir = i_bus_wdata[2:0];
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            dir_ff <= gnio_pkg::DIR_RESET;
        end else begin
            dir_ff <= nxt_dir;
        end
    end

    // read data: pins for ports, stored bits for direction, zero elsewhere
    always_comb begin
        nxt_rdata = gnio_pkg::RDATA_IDLE;
        if (i_bus_rd) begin
            if (hit_dir) begin
                nxt_rdata = {1'b0, dir_ff};
            end else if (hit_a) begin
                nxt_rdata = i_pa_in;
            end else if (hit_b) begin
                nxt_rdata = i_pb_in;
            end else if (hit_c) begin
                nxt_rdata = i_pc_in;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_ff <= gnio_pkg::RDATA_IDLE;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign o_bus_rdata = rdata_ff;

    gnio_nibble_port #(.OPEN_DRAIN(1'b0)) u_port_a (
        .i_clk(i_sys_clk),
        .i_rst_b(rst_b),
        .i_wr(i_bus_wr && hit_a),
        .i_wdata(i_bus_wdata),
        .i_dir_out(dir_ff[gnio_pkg::FIRST_PORT_DIR_SELECT]),
        .o_latch(latch_a),
        .o_pin_out(o_pa_out),
        .o_pin_oe_b(o_pa_oe_b),
        .o_pull_up_en(o_pa_pull_up_en)
    );

    gnio_nibble_port #(.OPEN_DRAIN(1'b1)) u_port_b (
        .i_clk(i_sys_clk),
        .i_rst_b(rst_b),
        .i_wr(i_bus_wr && hit_b),
        .i_wdata(i_bus_wdata),
        .i_dir_out(dir_ff[gnio_pkg::SECOND_PORT_DIR_SELECT]),
        .o_latch(latch_b),
        .o_pin_out(o_pb_out),
        .o_pin_oe_b(o_pb_oe_b),
        .o_pull_up_en()
    );

    gnio_nibble_port #(.OPEN_DRAIN(1'b1)) u_port_c (
        .i_clk(i_sys_clk),
        .i_rst_b(rst_b),
        .i_wr(i_bus_wr && hit_c),
        .i_wdata(i_bus_wdata),
        .i_dir_out(dir_ff[gnio_pkg::THIRD_PORT_DIR_SELECT]),
        .o_latch(latch_c),
        .o_pin_out(o_pc_out),
        .o_pin_oe_b(o_pc_oe_b),
        .o_pull_up_en()
    );

    // checks
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!rst_b);

    property p_whole_nibble;
        (o_pa_oe_b == gnio_pkg::NIB_ALL_OFF) || (o_pa_oe_b == gnio_pkg::NIB_ALL_ON);
    endproperty
    a_whole_nibble: assert property (p_whole_nibble) else $error("first port pins differ in direction");

    property p_dir_a;
        i_bus_wr && hit_dir && !i_wdt_rst ##1 !i_wdt_rst && !(i_bus_wr && hit_dir)
            |=> (o_pa_oe_b == {4{~$past(i_bus_wdata[0], 2)}});
    endproperty
    a_dir_a: assert property (p_dir_a) else $error("first port direction not from bit 0");

    property p_dir_b;
        (|(~o_pb_oe_b)) |-> $past(dir_ff[gnio_pkg::SECOND_PORT_DIR_SELECT]);
    endproperty
    a_dir_b: assert property (p_dir_b) else $error("second port drives without bit 1");

    property p_dir_c;
        $past(dir_ff[gnio_pkg::THIRD_PORT_DIR_SELECT]) |-> (o_pc_oe_b == ($past(latch_c) ^ gnio_pkg::NIB_ALL_ON));
    endproperty
    a_dir_c: assert property (p_dir_c) else $error("third port drive not from bit 2 and latch");

    property p_read_a;
        i_bus_rd && !i_bus_rf_sel && i_bus_bank == gnio_pkg::DATA_BANK_ZERO
            && i_bus_addr == gnio_pkg::ADDR_PORT_A |=> o_bus_rdata == $past(i_pa_in);
    endproperty
    a_read_a: assert property (p_read_a) else $error("read of first port wrong");

    property p_read_b;
        i_bus_rd && !i_bus_rf_sel && i_bus_bank == gnio_pkg::DATA_BANK_ZERO
            && i_bus_addr == gnio_pkg::ADDR_PORT_B |=> o_bus_rdata == $past(i_pb_in);
    endproperty
    a_read_b: assert property (p_read_b) else $error("read of second port wrong");

    property p_read_c;
        i_bus_rd && !i_bus_rf_sel && i_bus_bank == gnio_pkg::DATA_BANK_ZERO
            && i_bus_addr == gnio_pkg::ADDR_PORT_C |=> o_bus_rdata == $past(i_pc_in);
    endproperty
    a_read_c: assert property (p_read_c) else $error("read of third port wrong");

    property p_write_out;
        i_bus_wr && hit_a ##1 !(i_bus_wr && hit_a) |=> o_pa_out == $past(i_bus_wdata, 2);
    endproperty
    a_write_out: assert property (p_write_out) else $error("first port output data not written");

    property p_idle_rdata;
        !i_bus_rd |=> o_bus_rdata == gnio_pkg::RDATA_IDLE;
    endproperty
    a_idle_rdata: assert property (p_idle_rdata) else $error("read data outside read answer");

    property p_wdt_input;
        i_wdt_rst |=> dir_ff == gnio_pkg::DIR_RESET ##1 (o_pa_oe_b == gnio_pkg::NIB_ALL_OFF)
            && (o_pb_oe_b == gnio_pkg::NIB_ALL_OFF) && (o_pc_oe_b == gnio_pkg::NIB_ALL_OFF);
    endproperty
    a_wdt_input: assert property (p_wdt_input) else $error("watchdog reset left a port driving");

    property p_pull_up;
        o_pa_pull_up_en == ~$past(dir_ff[gnio_pkg::FIRST_PORT_DIR_SELECT]);
    endproperty
    a_pull_up: assert property (p_pull_up) else $error("first port pull-up wrong");

    property p_open_drain;
        (o_pb_out == gnio_pkg::NIB_ALL_ON) && (o_pc_out == gnio_pkg::NIB_ALL_ON);
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("open-drain port drives high");

    property p_held_latch;
        $rose(dir_ff[gnio_pkg::FIRST_PORT_DIR_SELECT]) && !(i_bus_wr && hit_a)
            |=> o_pa_out == $past(latch_a) && o_pa_oe_b == gnio_pkg::NIB_ALL_ON;
    endproperty
    a_held_latch: assert property (p_held_latch) else $error("held latch not shown on output");

    property p_input_b;
        !$past(dir_ff[gnio_pkg::SECOND_PORT_DIR_SELECT]) |-> o_pb_oe_b == gnio_pkg::NIB_ALL_OFF;
    endproperty
    a_input_b: assert property (p_input_b) else $error("second port drives in input mode");

    property p_input_c;
        !$past(dir_ff[gnio_pkg::THIRD_PORT_DIR_SELECT]) |-> o_pc_oe_b == gnio_pkg::NIB_ALL_OFF;
    endproperty
    a_input_c: assert property (p_input_c) else $error("third port drives in input mode");

    property p_follow_a;
        o_pa_oe_b == {gnio_pkg::NIB_W{~$past(dir_ff[gnio_pkg::FIRST_PORT_DIR_SELECT])}};
    endproperty
    a_follow_a: assert property (p_follow_a) else $error("first port enable not from bit 0");

    property p_fall_a;
        $fell(dir_ff[gnio_pkg::FIRST_PORT_DIR_SELECT]) |=> o_pa_oe_b == gnio_pkg::NIB_ALL_OFF;
    endproperty
    a_fall_a: assert property (p_fall_a) else $error("first port still drives after input");

    property p_latch_b;
        $past(dir_ff[gnio_pkg::SECOND_PORT_DIR_SELECT]) |-> o_pb_oe_b == $past(latch_b);
    endproperty
    a_latch_b: assert property (p_latch_b) else $error("second port drive not from latch");

    property p_fall_b;
        $fell(dir_ff[gnio_pkg::SECOND_PORT_DIR_SELECT]) |=> o_pb_oe_b == gnio_pkg::NIB_ALL_OFF;
    endproperty
    a_fall_b: assert property (p_fall_b) else $error("second port still drives after input");

    property p_rise_b;
        $rose(dir_ff[gnio_pkg::SECOND_PORT_DIR_SELECT]) |=> o_pb_oe_b == $past(latch_b);
    endproperty
    a_rise_b: assert property (p_rise_b) else $error("second port held latch not shown");

    property p_fall_c;
        $fell(dir_ff[gnio_pkg::THIRD_PORT_DIR_SELECT]) |=> o_pc_oe_b == gnio_pkg::NIB_ALL_OFF;
    endproperty
    a_fall_c: assert property (p_fall_c) else $error("third port still drives after input");

    property p_rise_c;
        $rose(dir_ff[gnio_pkg::THIRD_PORT_DIR_SELECT]) |=> o_pc_oe_b == $past(latch_c);
    endproperty
    a_rise_c: assert property (p_rise_c) else $error("third port held latch not shown");

    property p_write_a;
        i_bus_wr && !i_bus_rf_sel && i_bus_bank == gnio_pkg::DATA_BANK_ZERO
            && i_bus_addr == gnio_pkg::ADDR_PORT_A |=> latch_a == $past(i_bus_wdata);
    endproperty
    a_write_a: assert property (p_write_a) else $error("first port latch not written");

    property p_write_b;
        i_bus_wr && !i_bus_rf_sel && i_bus_bank == gnio_pkg::DATA_BANK_ZERO
            && i_bus_addr == gnio_pkg::ADDR_PORT_B |=> latch_b == $past(i_bus_wdata);
    endproperty
    a_write_b: assert property (p_write_b) else $error("second port latch not written");

    property p_write_c;
        i_bus_wr && !i_bus_rf_sel && i_bus_bank == gnio_pkg::DATA_BANK_ZERO
            && i_bus_addr == gnio_pkg::ADDR_PORT_C |=> latch_c == $past(i_bus_wdata);
    endproperty
    a_write_c: assert property (p_write_c) else $error("third port latch not written");

    property p_keep_a;
        !(i_bus_wr && hit_a) |=> $stable(latch_a);
    endproperty
    a_keep_a: assert property (p_keep_a) else $error("first port latch changed without write");

    property p_keep_b;
        !(i_bus_wr && hit_b) |=> $stable(latch_b);
    endproperty
    a_keep_b: assert property (p_keep_b) else $error("second port latch changed without write");

    property p_keep_c;
        !(i_bus_wr && hit_c) |=> $stable(latch_c);
    endproperty
    a_keep_c: assert property (p_keep_c) else $error("third port latch changed without write");

    property p_dir_write;
        i_bus_wr && hit_dir && !i_wdt_rst |=> dir_ff == $past(i_bus_wdata[gnio_pkg::THIRD_PORT_DIR_SELECT:0]);
    endproperty
    a_dir_write: assert property (p_dir_write) else $error("direction write lost");

    property p_dir_hold;
        !i_wdt_rst && !(i_bus_wr && hit_dir) |=> $stable(dir_ff);
    endproperty
    a_dir_hold: assert property (p_dir_hold) else $error("direction changed without write");

    property p_read_dir;
        i_bus_rd && i_bus_rf_sel && i_bus_addr == gnio_pkg::ADDR_DIR_GROUPS
            |=> o_bus_rdata == {1'b0, $past(dir_ff)};
    endproperty
    a_read_dir: assert property (p_read_dir) else $error("direction read wrong");

    property p_read_bank;
        i_bus_rd && !i_bus_rf_sel && i_bus_bank != gnio_pkg::DATA_BANK_ZERO
            |=> o_bus_rdata == gnio_pkg::RDATA_IDLE;
    endproperty
    a_read_bank: assert property (p_read_bank) else $error("port read outside bank zero");

    property p_write_bank;
        i_bus_wr && !i_bus_rf_sel && i_bus_bank != gnio_pkg::DATA_BANK_ZERO
            |=> $stable(latch_a) && $stable(latch_b) && $stable(latch_c);
    endproperty
    a_write_bank: assert property (p_write_bank) else $error("port latch written outside bank zero");

    property p_wdt_latch;
        i_wdt_rst && !i_bus_wr
            |=> $stable(latch_a) && $stable(latch_b) && $stable(latch_c);
    endproperty
    a_wdt_latch: assert property (p_wdt_latch) else $error("watchdog reset changed a latch");

    property p_pull_in;
        o_pa_oe_b == gnio_pkg::NIB_ALL_OFF |-> o_pa_pull_up_en;
    endproperty
    a_pull_in: assert property (p_pull_in) else $error("pull-up off in input mode");

    property p_pull_drive;
        o_pa_oe_b == gnio_pkg::NIB_ALL_ON |-> !o_pa_pull_up_en;
    endproperty
    a_pull_drive: assert property (p_pull_drive) else $error("pull-up on while driving");

    c_write_input_then_out: cover property (i_bus_wr && hit_a && !dir_ff[gnio_pkg::FIRST_PORT_DIR_SELECT]
        ##[1:20] $rose(dir_ff[gnio_pkg::FIRST_PORT_DIR_SELECT]));
    c_wdt_while_out: cover property (dir_ff == ~gnio_pkg::DIR_RESET ##1 i_wdt_rst);
    c_od_pull_low: cover property (o_pb_oe_b != gnio_pkg::NIB_ALL_OFF && o_pc_oe_b != gnio_pkg::NIB_ALL_OFF);
    c_read_back: cover property (i_bus_rd && hit_dir ##1 o_bus_rdata != gnio_pkg::RDATA_IDLE);
endmodule

// ### verification/gnio_board.sv
// board around the three ports: pull-ups and optional outside drivers
// assumes the bench picks which nibbles the board drives and with what
`timescale 1ns/1ps
module gnio_board (
    input wire logic [3:0] i_pa_out,
    input wire logic [3:0] i_pa_oe_b,
    input wire logic i_pa_pull_up_en,
    input wire logic [3:0] i_pb_oe_b,
    input wire logic [3:0] i_pc_oe_b,
    input wire logic [2:0] i_ext_en,
    input wire logic [11:0] i_ext_val,
    output logic [3:0] o_pa,
    output logic [3:0] o_pb,
    output logic [3:0] o_pc
);
    logic [3:0] pa_float;
    // undriven port a pin without pull-up shows the inverse of the present i_pa_out, which follows the latch in either direction
    assign pa_float = i_ext_en[0] ? i_ext_val[3:0] : (i_pa_pull_up_en ? 4'hF : ~i_pa_out);
    assign o_pa = (~i_pa_oe_b & i_pa_out) | (i_pa_oe_b & pa_float);
    // wired-and: the device only pulls low, the board resistor pulls high
    assign o_pb = i_pb_oe_b & (i_ext_en[1] ? i_ext_val[7:4] : 4'hF);
    assign o_pc = i_pc_oe_b & (i_ext_en[2] ? i_ext_val[11:8] : 4'hF);
endmodule

// ### verification/test_gnio_top.sv
// self-checking bench for the grouped nibble ports
// assumes the board model resolves every pin level
`timescale 1ns/1ps
module test_gnio_top;
    logic i_sys_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic wdt = 1'b0;
    logic [7:0] addr = 8'h00;
    logic rf = 1'b0;
    logic [1:0] bank = 2'h0;
    logic [3:0] wdata = 4'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [3:0] rdata, pa_in, pb_in, pc_in, pa_out, pa_oe_b, pb_out, pb_oe_b, pc_out, pc_oe_b;
    logic pa_pu;
    logic [2:0] ext_en = 3'h0;
    logic [11:0] ext_val = 12'h000;
    int error_cnt = 0;
    int samples_checked = 0;
    int cycles = 0;

    gnio_top u_gnio_top (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_wdt_rst(wdt), .i_bus_addr(addr),
        .i_bus_rf_sel(rf), .i_bus_bank(bank), .i_bus_wdata(wdata), .i_bus_wr(wr), .i_bus_rd(rd),
        .o_bus_rdata(rdata), .i_pa_in(pa_in), .o_pa_out(pa_out), .o_pa_oe_b(pa_oe_b),
        .o_pa_pull_up_en(pa_pu), .i_pb_in(pb_in), .o_pb_out(pb_out), .o_pb_oe_b(pb_oe_b),
        .i_pc_in(pc_in), .o_pc_out(pc_out), .o_pc_oe_b(pc_oe_b));
    gnio_board u_gnio_board (.i_pa_out(pa_out), .i_pa_oe_b(pa_oe_b), .i_pa_pull_up_en(pa_pu),
        .i_pb_oe_b(pb_oe_b), .i_pc_oe_b(pc_oe_b), .i_ext_en(ext_en), .i_ext_val(ext_val),
        .o_pa(pa_in), .o_pb(pb_in), .o_pc(pc_in));

    initial begin
        forever #20 i_sys_clk = ~i_sys_clk;
    end

    task automatic end_of_test;
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    always @(posedge i_sys_clk) begin
        cycles++;
        if (cycles == 2000) begin
            error_cnt++;
            end_of_test();
        end
    end

    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic bus_wr(input logic s, input logic [1:0] b, input logic [7:0] a, input logic [3:0] d);
        @(posedge i_sys_clk);
        rf <= s;
        bank <= b;
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge i_sys_clk);
        wr <= 1'b0;
    endtask

    task automatic bus_rd(input logic s, input logic [1:0] b, input logic [7:0] a, input logic [3:0] e);
        @(posedge i_sys_clk);
        rf <= s;
        bank <= b;
        addr <= a;
        rd <= 1'b1;
        @(posedge i_sys_clk);
        rd <= 1'b0;
        #1;
        chk(rdata, e);
    endtask

    task automatic settle;
        @(posedge i_sys_clk);
        #1;
    endtask

    task automatic do_reset;
        i_rst_b <= 1'b0;
        repeat (20) @(posedge i_sys_clk);
        i_rst_b <= 1'b1;
        repeat (3) @(posedge i_sys_clk);
        #1;
    endtask

    task automatic t_reset_state;
        chk(pa_oe_b & pb_oe_b & pc_oe_b, 4'hF);
        chk({3'h0, pa_pu}, 4'h1);
        bus_rd(1'b0, 2'h0, 8'h70, 4'hF);
        bus_rd(1'b0, 2'h0, 8'h71, 4'hF);
        bus_rd(1'b1, 2'h0, 8'h37, 4'h0);
    endtask

    task automatic t_dirs;
        bus_wr(1'b0, 2'h0, 8'h70, 4'h5);
        bus_wr(1'b0, 2'h0, 8'h71, 4'hA);
        bus_wr(1'b0, 2'h0, 8'h72, 4'h3);
        ext_en <= 3'h1;
        ext_val <= 12'h006;
        bus_rd(1'b0, 2'h0, 8'h70, 4'h6);
        ext_en <= 3'h0;
        bus_wr(1'b1, 2'h0, 8'h37, 4'h1);
        settle();
        chk(pa_oe_b, 4'h0);
        chk(pa_out, 4'h5);
        chk({3'h0, pa_pu}, 4'h0);
        chk(pb_oe_b & pc_oe_b, 4'hF);
        bus_rd(1'b0, 2'h0, 8'h70, 4'h5);
        bus_wr(1'b1, 2'h0, 8'h37, 4'h6);
        settle();
        chk(pa_oe_b, 4'hF);
        chk(pb_oe_b, 4'hA);
        chk(pc_oe_b, 4'h3);
        chk(pb_out | pc_out, 4'h0);
        bus_rd(1'b0, 2'h0, 8'h71, 4'hA);
        bus_rd(1'b0, 2'h0, 8'h72, 4'h3);
    endtask

    task automatic t_refuse;
        bus_wr(1'b0, 2'h1, 8'h70, 4'h0);
        bus_wr(1'b1, 2'h0, 8'h70, 4'h0);
        bus_wr(1'b1, 2'h0, 8'h37, 4'hF);
        bus_rd(1'b1, 2'h0, 8'h37, 4'h7);
        bus_rd(1'b0, 2'h0, 8'h73, 4'h0);
        bus_rd(1'b0, 2'h1, 8'h70, 4'h0);
        bus_rd(1'b0, 2'h0, 8'h70, 4'h5);
    endtask

    task automatic t_wdt;
        @(posedge i_sys_clk);
        wdt <= 1'b1;
        @(posedge i_sys_clk);
        wdt <= 1'b0;
        settle();
        chk(pa_oe_b & pb_oe_b & pc_oe_b, 4'hF);
        chk({3'h0, pa_pu}, 4'h1);
        bus_rd(1'b1, 2'h0, 8'h37, 4'h0);
        bus_wr(1'b1, 2'h0, 8'h37, 4'h1);
        settle();
        chk(pa_out, 4'h5);
        chk(pa_oe_b, 4'h0);
    endtask

    task automatic t_pin_reset;
        bus_wr(1'b1, 2'h0, 8'h37, 4'h7);
        @(posedge i_sys_clk);
        i_rst_b <= 1'b0;
        #1;
        chk(pa_oe_b & pb_oe_b & pc_oe_b, 4'hF);
        do_reset();
        bus_rd(1'b1, 2'h0, 8'h37, 4'h0);
    endtask

    initial begin
        do_reset();
        t_reset_state();
        t_dirs();
        t_refuse();
        t_wdt();
        t_pin_reset();
        end_of_test();
    end
endmodule
